// ===== include/cioc_pkg.sv
// Shared constants, types and register map of the configurable I/O counter block.
package cioc_pkg;

  // Structure of the channel bank.
  localparam int unsigned CH_NUM = 32;
  localparam int unsigned BLK_NUM = 4;
  localparam int unsigned BLK_CH = 8;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned MATCH_NUM = 2;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses; groups hold one word per block or bank, the channel group one word per channel.
  localparam logic [7:0] REG_PIN_LEVEL = 8'h00;
  localparam logic [7:0] REG_EVENT = 8'h04;
  localparam logic [7:0] REG_FUNC_BASE = 8'h10;
  localparam logic [7:0] REG_CFG_BASE = 8'h20;
  localparam logic [7:0] REG_OPT_BASE = 8'h30;
  localparam logic [7:0] REG_BANK_BASE = 8'h40;
  localparam logic [7:0] REG_LIMIT_BASE = 8'h50;
  localparam logic [7:0] REG_COUNT_BASE = 8'h60;
  localparam logic [7:0] REG_STAT_BASE = 8'h70;
  localparam logic [7:0] REG_CHAN_BASE = 8'h80;

  // Field positions of the channel function word, the option word and the status word.
  localparam int unsigned FUNC_EDGE_LSB = 16;
  localparam int unsigned OPT_DN_CH_LSB = 0;
  localparam int unsigned OPT_DN_CH_W = 5;
  localparam int unsigned OPT_DN_EDGE_LSB = 8;
  localparam int unsigned STAT_INVALID_BIT = 8;

  // Reset values.
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [15:0] OPT_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] LIMIT_RST = 16'hffff;
  localparam logic [15:0] MATCH_MAX = 16'hffff;

  // Edge selection, shared by interrupt events and counter inputs.
  typedef enum logic [1:0] {
    COUNT_EDGE_NONE = 2'b00,
    COUNT_EDGE_RISING = 2'b01,
    COUNT_EDGE_FALLING = 2'b10,
    COUNT_EDGE_ANY = 2'b11
  } cioc_edge_t;
  localparam cioc_edge_t IRQ_EDGE_RISING = COUNT_EDGE_RISING;
  localparam cioc_edge_t IRQ_EDGE_FALLING = COUNT_EDGE_FALLING;
  localparam cioc_edge_t IRQ_EDGE_ANY = COUNT_EDGE_ANY;

  // Per-channel function.
  typedef enum logic [1:0] {
    FN_INPUT = 2'b00,
    FN_IRQ = 2'b01,
    FN_COUNTER = 2'b10,
    FN_QUAD = 2'b11
  } cioc_func_t;

  // Block counter mode.
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_CONTINUOUS_UP = 3'b001,
    MODE_UP_DOWN = 3'b010,
    MODE_STOP_ON_MATCH = 3'b011,
    MODE_QUAD = 3'b100
  } cioc_mode_t;

  // Block configuration word, channel fields are indices inside the block.
  typedef struct packed {
    logic [11:0] rsvd;
    logic sync_en;
    logic [2:0] sync_ch;
    logic idx_pol;
    logic idx_en;
    logic [2:0] idx_ch;
    logic [2:0] b_ch;
    cioc_edge_t up_edge;
    logic [2:0] a_ch;
    cioc_mode_t mode;
  } cioc_blk_cfg_t;

endpackage

// ===== hdl/cioc_pin_sync.sv
// Pin synchroniser with agreement filter and edge pulses.
`timescale 1ns/100ps
module cioc_pin_sync #(
  parameter int unsigned W = 32
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Raw pins.
  input wire logic [W-1:0] pins_i,
  // Filtered level and one-cycle edge pulses.
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_reg;
  logic [W-1:0] level_next;
  logic [W-1:0] rise_reg;
  logic [W-1:0] fall_reg;

  // Three-stage chain; only the second stage reads the first.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= pins_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A level changes only when stages two and three agree, which rejects one-cycle glitches.
  assign level_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & level_reg);

  // Edges come from the filtered level, so a cycle carries at most one edge per pin.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      level_reg <= '0;
      rise_reg <= '0;
      fall_reg <= '0;
    end
    else
    begin
      level_reg <= level_next;
      rise_reg <= level_next & ~level_reg;
      fall_reg <= ~level_next & level_reg;
    end
  end

  assign level_o = level_reg;
  assign rise_o = rise_reg;
  assign fall_o = fall_reg;

  a_one_edge: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) (rise_o & fall_o) == '0)
    else $error("Pin shows both edges in one cycle.");

endmodule

// ===== hdl/cioc_top.sv
// Configurable I/O channel bank with per-block edge, up/down, match and quadrature counters.
`timescale 1ns/100ps
module cioc_top
  import cioc_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Field pins.
  input wire logic [CH_NUM-1:0] config_io_pins_i,
  // Register port.
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // Interrupt-source events, one cycle per detected edge.
  output logic [CH_NUM-1:0] irq_event_o
);

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic [CH_NUM-1:0] pin_level;
  logic [CH_NUM-1:0] pin_rise;
  logic [CH_NUM-1:0] pin_fall;
  logic [CH_NUM-1:0] irq_hit;
  logic [CH_NUM-1:0] event_reg;
  logic [CH_NUM-1:0] irq_event_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rd_next;
  logic [1:0] idx;
  logic chan_bit;
  logic [7:0] bank_byte;
  logic [31:0] func_reg [BLK_NUM];
  logic [31:0] cfg_reg [BLK_NUM];
  logic [15:0] opt_reg [BLK_NUM];
  logic [CNT_W-1:0] limit_pend_reg [BLK_NUM];
  logic [CNT_W-1:0] limit_act_reg [BLK_NUM];
  logic [CNT_W-1:0] count_reg [BLK_NUM];
  logic [CNT_W-1:0] match_reg [BLK_NUM][MATCH_NUM];
  logic [8:0] stat_reg [BLK_NUM];
  logic [2:0] dn_ch_reg [BLK_NUM];
  cioc_edge_t dn_edge_reg [BLK_NUM];
  logic halted_reg [BLK_NUM];
  logic qa_prev_reg [BLK_NUM];
  logic qb_prev_reg [BLK_NUM];

  // True when the address selects word n of a four-word group.
  function automatic logic sel_hit(input logic [7:0] addr, input logic [7:0] base,
                                   input logic [1:0] n);
    sel_hit = (addr[7:4] == base[7:4]) && (addr[3:2] == n) && (addr[1:0] == 2'b00);
  endfunction

  // True when a rise or fall pulse matches the edge selection.
  function automatic logic edge_hit(input cioc_edge_t sel, input logic rise, input logic fall);
    edge_hit = (sel[0] & rise) | (sel[1] & fall);
  endfunction

  // Function code of channel c in a bank's function word.
  function automatic cioc_func_t chan_func(input logic [31:0] word, input logic [2:0] c);
    chan_func = cioc_func_t'(word[{c, 1'b0} +: 2]);
  endfunction

  // All pins go through the synchroniser before any edge logic.
  cioc_pin_sync #(
    .W(CH_NUM)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pins_i(config_io_pins_i),
    .level_o(pin_level),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // Interrupt-source events per channel from its own edge setting.
  for (genvar c = 0; c < CH_NUM; c++)
  begin : g_irq
    assign irq_hit[c] = (chan_func(func_reg[c/BLK_CH], 3'(c % BLK_CH)) == FN_IRQ) &&
      edge_hit(cioc_edge_t'(func_reg[c/BLK_CH][FUNC_EDGE_LSB + 2*(c % BLK_CH) +: 2]),
               pin_rise[c], pin_fall[c]);
  end

  // Sticky event flags; a new event wins over a write-one clear in the same cycle.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      event_reg <= '0;
      irq_event_reg <= '0;
    end
    else
    begin
      event_reg <= (event_reg & ~((wr_i && addr_i == REG_EVENT) ? wdata_i : '0)) | irq_hit;
      irq_event_reg <= irq_hit;
    end
  end

  // Channel function words, option words and pending limits, one per block.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < BLK_NUM; i++)
      begin
        func_reg[i] <= CFG_RST;
        opt_reg[i] <= OPT_RST;
        limit_pend_reg[i] <= LIMIT_RST;
      end
    end
    else if (wr_i)
    begin
      for (int i = 0; i < BLK_NUM; i++)
      begin
        if (sel_hit(addr_i, REG_FUNC_BASE, 2'(i)))
          func_reg[i] <= wdata_i;
        if (sel_hit(addr_i, REG_OPT_BASE, 2'(i)))
          opt_reg[i] <= wdata_i[15:0];
        if (sel_hit(addr_i, REG_LIMIT_BASE, 2'(i)))
          limit_pend_reg[i] <= wdata_i[15:0];
      end
    end
  end

  // Counter blocks, each sharing one counter among its eight channels.
  for (genvar b = 0; b < BLK_NUM; b++)
  begin : g_blk
    localparam logic [1:0] BI = 2'(b);
    cioc_blk_cfg_t cur;
    cioc_blk_cfg_t req;
    cioc_func_t want;
    logic [BLK_CH-1:0] need;
    logic [BLK_CH-1:0] conflict;
    logic [BLK_CH-1:0] blk_level;
    logic [BLK_CH-1:0] blk_rise;
    logic [BLK_CH-1:0] blk_fall;
    logic [4:0] dn_glob;
    logic invalid;
    logic cfg_wr;
    logic cnt_wr;
    logic accept;
    logic clear;
    logic up_hit;
    logic dn_hit;
    logic step;
    logic up_dir;
    logic match_now;
    logic inc;
    logic dec;

    assign cur = cioc_blk_cfg_t'(cfg_reg[b]);
    assign req = cioc_blk_cfg_t'(wdata_i);
    assign dn_glob = opt_reg[b][OPT_DN_CH_LSB +: OPT_DN_CH_W];
    assign blk_level = pin_level[b*BLK_CH +: BLK_CH];
    assign blk_rise = pin_rise[b*BLK_CH +: BLK_CH];
    assign blk_fall = pin_fall[b*BLK_CH +: BLK_CH];
    assign cfg_wr = wr_i && sel_hit(addr_i, REG_CFG_BASE, BI);
    assign cnt_wr = wr_i && sel_hit(addr_i, REG_COUNT_BASE, BI);

    // Pins a requested mode relies on, and the channel function they must carry.
    always_comb
    begin
      need = '0;
      want = FN_COUNTER;
      invalid = 1'b0;
      unique case (req.mode)
        MODE_OFF:
        begin
          need = '0;
        end
        MODE_CONTINUOUS_UP, MODE_STOP_ON_MATCH:
        begin
          need[req.a_ch] = 1'b1;
        end
        MODE_UP_DOWN:
        begin
          need[req.a_ch] = 1'b1;
          need[dn_glob[2:0]] = 1'b1;
          invalid = (dn_glob[4:3] != BI) || (dn_glob[2:0] == req.a_ch);
        end
        MODE_QUAD:
        begin
          want = FN_QUAD;
          need[req.a_ch] = 1'b1;
          need[req.b_ch] = 1'b1;
          if (req.idx_en)
            need[req.idx_ch] = 1'b1;
        end
        default:
        begin
          invalid = 1'b1;
        end
      endcase
    end

    // A needed pin whose function does not match is a conflict.
    for (genvar c = 0; c < BLK_CH; c++)
    begin : g_conf
      assign conflict[c] = need[c] && (chan_func(func_reg[b], 3'(c)) != want);
    end

    assign accept = cfg_wr && (conflict == '0) && !invalid;

    // Edge and phase events for the configured inputs.
    assign up_hit = edge_hit(cur.up_edge, blk_rise[cur.a_ch], blk_fall[cur.a_ch]);
    assign dn_hit = edge_hit(dn_edge_reg[b], blk_rise[dn_ch_reg[b]], blk_fall[dn_ch_reg[b]]);
    assign step = (blk_level[cur.a_ch] ^ qa_prev_reg[b]) ^ (blk_level[cur.b_ch] ^ qb_prev_reg[b]);
    assign up_dir = blk_level[cur.a_ch] ^ qb_prev_reg[b];

    // Any match register equal to the count is a match event.
    always_comb
    begin
      match_now = 1'b0;
      for (int m = 0; m < MATCH_NUM; m++)
        match_now = match_now | (count_reg[b] == match_reg[b][m]);
    end

    // Count direction per mode; both edges at once in up/down cancel out.
    always_comb
    begin
      inc = 1'b0;
      dec = 1'b0;
      unique case (cur.mode)
        MODE_OFF:
        begin
          inc = 1'b0;
        end
        MODE_CONTINUOUS_UP:
        begin
          inc = up_hit;
        end
        MODE_UP_DOWN:
        begin
          inc = up_hit && !dn_hit;
          dec = dn_hit && !up_hit;
        end
        MODE_STOP_ON_MATCH:
        begin
          inc = up_hit && !halted_reg[b] && !match_now;
        end
        MODE_QUAD:
        begin
          inc = step && up_dir;
          dec = step && !up_dir;
        end
      endcase
    end

    // Host reset, a new configuration, sync edge or active index all clear the count.
    assign clear = cnt_wr || accept || (cur.sync_en && blk_rise[cur.sync_ch]) ||
      (cur.mode == MODE_QUAD && cur.idx_en && (blk_level[cur.idx_ch] == cur.idx_pol));

    // Configuration, down input and match registers load only on an accepted request.
    always_ff @(posedge ref_clk_i)
    begin
      if (!rst_n_i)
      begin
        cfg_reg[b] <= CFG_RST;
        stat_reg[b] <= '0;
        dn_ch_reg[b] <= '0;
        dn_edge_reg[b] <= COUNT_EDGE_NONE;
        for (int m = 0; m < MATCH_NUM; m++)
          match_reg[b][m] <= MATCH_MAX;
      end
      else if (cfg_wr)
      begin
        stat_reg[b] <= {invalid, conflict};
        if (accept)
        begin
          cfg_reg[b] <= wdata_i;
          if (req.mode == MODE_UP_DOWN)
          begin
            dn_ch_reg[b] <= dn_glob[2:0];
            dn_edge_reg[b] <= cioc_edge_t'(opt_reg[b][OPT_DN_EDGE_LSB +: 2]);
          end
          if (req.mode == MODE_STOP_ON_MATCH)
          begin
            match_reg[b][0] <= opt_reg[b];
            for (int m = 1; m < MATCH_NUM; m++)
              match_reg[b][m] <= MATCH_MAX;
          end
        end
      end
    end

    // The sixteen-bit counter; the pending limit is adopted only on an upward wrap or clear.
    always_ff @(posedge ref_clk_i)
    begin
      if (!rst_n_i)
      begin
        count_reg[b] <= COUNT_RST;
        limit_act_reg[b] <= LIMIT_RST;
      end
      else if (clear)
      begin
        count_reg[b] <= COUNT_RST;
        limit_act_reg[b] <= limit_pend_reg[b];
      end
      else if (inc)
      begin
        if (count_reg[b] == limit_act_reg[b])
        begin
          count_reg[b] <= COUNT_RST;
          limit_act_reg[b] <= limit_pend_reg[b];
        end
        else
          count_reg[b] <= CNT_W'(count_reg[b] + 1'b1);
      end
      else if (dec)
      begin
        count_reg[b] <= (count_reg[b] == COUNT_RST) ? limit_act_reg[b] :
          CNT_W'(count_reg[b] - 1'b1);
      end
    end

    // Halt latch and previous quadrature levels.
    always_ff @(posedge ref_clk_i)
    begin
      if (!rst_n_i)
      begin
        halted_reg[b] <= 1'b0;
        qa_prev_reg[b] <= 1'b0;
        qb_prev_reg[b] <= 1'b0;
      end
      else
      begin
        if (clear)
          halted_reg[b] <= 1'b0;
        else if (cur.mode == MODE_STOP_ON_MATCH && match_now)
          halted_reg[b] <= 1'b1;
        qa_prev_reg[b] <= blk_level[cur.a_ch];
        qb_prev_reg[b] <= blk_level[cur.b_ch];
      end
    end

    a_conflict_report: assert property (cfg_wr && !accept |=>
        stat_reg[b] != '0 && $stable(cfg_reg[b]))
      else $error("Rejected request left no bitmap or changed the block.");
    a_up_count: assert property (cur.mode == MODE_CONTINUOUS_UP && up_hit && !clear &&
        count_reg[b] != limit_act_reg[b] |=> count_reg[b] == CNT_W'($past(count_reg[b]) + 1'b1))
      else $error("Up edge did not add one to the count.");
    a_quad_step: assert property (cur.mode == MODE_QUAD && step && !up_dir && !clear &&
        count_reg[b] != COUNT_RST |=> count_reg[b] == CNT_W'($past(count_reg[b]) - 1'b1))
      else $error("Reverse quadrature step did not subtract one.");
    a_match_halt: assert property (cur.mode == MODE_STOP_ON_MATCH && match_now && !clear
        |=> halted_reg[b] ##1 (halted_reg[b] || $past(clear)))
      else $error("Match event did not halt the counter.");
    a_match_fill: assert property (accept && req.mode == MODE_STOP_ON_MATCH |=>
        match_reg[b][0] == $past(opt_reg[b]) && match_reg[b][1] == MATCH_MAX)
      else $error("Match registers not loaded for stop-on-match.");
    a_sync_clear: assert property (cur.sync_en && blk_rise[cur.sync_ch] |=>
        count_reg[b] == COUNT_RST)
      else $error("Synchronisation edge did not clear the count.");
    a_index_clear: assert property (cur.mode == MODE_QUAD && cur.idx_en &&
        blk_level[cur.idx_ch] == cur.idx_pol |=> count_reg[b] == COUNT_RST)
      else $error("Active index did not clear the count.");
    a_host_reset: assert property (cnt_wr |=> count_reg[b] == COUNT_RST &&
        limit_act_reg[b] == $past(limit_pend_reg[b]))
      else $error("Host reset did not clear count and adopt limit.");
    a_limit_defer: assert property (!clear && !(inc && count_reg[b] == limit_act_reg[b])
        |=> $stable(limit_act_reg[b]))
      else $error("Limit changed without overflow or reset.");
    a_dn_pin_apart: assert property (accept && req.mode == MODE_UP_DOWN |=>
        dn_ch_reg[b] != cur.a_ch)
      else $error("Down input shares the up pin.");
  end

  // Read decode; unmapped addresses below the channel group read as zero.
  assign idx = addr_i[3:2];
  assign chan_bit = pin_level[addr_i[6:2]];
  assign bank_byte = pin_level[{idx, 3'b000} +: 8];

  always_comb
  begin
    rd_next = '0;
    if (addr_i[7] == REG_CHAN_BASE[7])
      rd_next = {31'h0000_0000, chan_bit};
    else if (addr_i[1:0] == 2'b00)
    begin
      case (addr_i[7:4])
        REG_PIN_LEVEL[7:4]: rd_next = (idx == REG_EVENT[3:2]) ? event_reg :
          ((idx == REG_PIN_LEVEL[3:2]) ? pin_level : '0);
        REG_FUNC_BASE[7:4]: rd_next = func_reg[idx];
        REG_CFG_BASE[7:4]: rd_next = cfg_reg[idx];
        REG_OPT_BASE[7:4]: rd_next = {16'h0000, opt_reg[idx]};
        REG_BANK_BASE[7:4]: rd_next = {24'h00_0000, bank_byte};
        REG_LIMIT_BASE[7:4]: rd_next = {16'h0000, limit_pend_reg[idx]};
        REG_COUNT_BASE[7:4]: rd_next = {16'h0000, count_reg[idx]};
        REG_STAT_BASE[7:4]: rd_next = {23'h00_0000, stat_reg[idx]};
        default: rd_next = '0;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe, which keeps the bus quiet otherwise.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      rdata_reg <= '0;
    else
      rdata_reg <= rd_i ? rd_next : '0;
  end

  assign rdata_o = rdata_reg;
  assign irq_event_o = irq_event_reg;

  a_chan_read: assert property (rd_i && addr_i[7] |=> rdata_o == {31'h0, $past(chan_bit)})
    else $error("Single channel read does not show the pin level.");
  a_bank_order: assert property (rd_i && addr_i[7:4] == REG_BANK_BASE[7:4] &&
      addr_i[1:0] == 2'b00 |=> rdata_o == {24'h0, $past(bank_byte)})
    else $error("Bank read returns wrong channel order.");
  a_event_sticky: assert property (irq_hit != '0 |=>
      (event_reg & $past(irq_hit)) == $past(irq_hit) && irq_event_o == $past(irq_hit))
    else $error("Interrupt edge lost.");

endmodule

// ===== verification/cioc_field_model.sv
// Field-side model: switches and pulse sources driving the channel pins.
`timescale 1ns/100ps
module cioc_field_model (
  // Clock.
  input wire logic ref_clk_i,
  // Pins towards the block.
  output logic [31:0] pins_o
);
  initial pins_o = 32'h0000_0000;

  // Sets all pins at once, just after a clock edge.
  task automatic set_all(input logic [31:0] v);
    @(posedge ref_clk_i);
    pins_o <= v;
  endtask

  // Pulses held 8 cycles per level, so the synchroniser filter never drops them.
  task automatic pulse(input int ch, input int n);
    repeat (n)
    begin
      @(posedge ref_clk_i);
      pins_o[ch] <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      pins_o[ch] <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
    end
  endtask
endmodule

// ===== verification/cioc_top_tb_top.sv
// Self-checking testbench of the configurable I/O counter block.
`timescale 1ns/100ps
module cioc_top_tb_top;
  import cioc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [31:0] pins;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [31:0] irq_event_o;
  int num_errors = 0;
  int checks_done = 0;
  int irq_cnt [32];
  logic [31:0] d;
  cioc_blk_cfg_t cfg;

  cioc_top cioc_top_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .config_io_pins_i(pins),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_event_o(irq_event_o));
  cioc_field_model cioc_field_model_i (.ref_clk_i(ref_clk_i), .pins_o(pins));

  // Clock of 8 ns.
  initial
  begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // Event pulses are counted per channel, since each lasts only one cycle.
  always @(posedge ref_clk_i)
  begin
    for (int i = 0; i < 32; i++) irq_cnt[i] += int'(irq_event_o[i]);
  end

  // One write, followed by an idle cycle so strobes are never assigned twice in a step.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    @(posedge ref_clk_i);
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    rd(a, d);
    checks_done++;
    if (d !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: addr %h got %h expected %h", $time, a, d, e);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Pin levels through the word, bank and single-channel views.
  task automatic t_levels();
    logic [31:0] p;
    p = 32'ha5c3_0f96;
    cioc_field_model_i.set_all(p);
    repeat (8) @(posedge ref_clk_i);
    chk(REG_PIN_LEVEL, p);
    for (int k = 0; k < 4; k++) chk(REG_BANK_BASE + 8'(4 * k), {24'h0, p[8 * k +: 8]});
    for (int n = 0; n < 32; n++) chk(REG_CHAN_BASE + 8'(4 * n), {31'h0, p[n]});
    chk(8'h08, 32'h0000_0000);
    cioc_field_model_i.set_all(32'h0000_0000);
    repeat (8) @(posedge ref_clk_i);
    chk(REG_BANK_BASE, 32'h0000_0000);
    $display("test levels done");
  endtask

  // Channels 1, 2 and 3 as event sources on rising, falling and any edge.
  task automatic t_irq();
    wr(REG_FUNC_BASE, 32'h00e4_0054);
    for (int i = 0; i < 32; i++) irq_cnt[i] = 0;
    for (int c = 0; c < 4; c++) cioc_field_model_i.pulse(c, 1);
    checks_done++;
    if (irq_cnt[0] != 0 || irq_cnt[1] != 1 || irq_cnt[2] != 1 || irq_cnt[3] != 2)
    begin
      num_errors++;
      $display("mismatch at %0t: event counts wrong", $time);
    end
    chk(REG_EVENT, 32'h0000_000e);
    wr(REG_EVENT, 32'h0000_0006);
    chk(REG_EVENT, 32'h0000_0008);
    $display("test irq done");
  endtask

  // Continuous up on falling edges, option word ignored, host reset, then a deferred limit.
  task automatic t_up();
    wr(REG_FUNC_BASE, 32'h0000_0002);
    wr(REG_OPT_BASE, 32'h0000_ffff);
    cfg = '0;
    cfg.mode = MODE_CONTINUOUS_UP;
    cfg.up_edge = COUNT_EDGE_FALLING;
    wr(REG_CFG_BASE, 32'(cfg));
    cioc_field_model_i.pulse(0, 3);
    chk(REG_COUNT_BASE, 32'h0000_0003);
    wr(REG_COUNT_BASE, 32'h0000_0000);
    chk(REG_COUNT_BASE, 32'h0000_0000);
    wr(REG_LIMIT_BASE, 32'h0000_0002);
    cioc_field_model_i.pulse(0, 3);
    chk(REG_COUNT_BASE, 32'h0000_0003);
    wr(REG_COUNT_BASE, 32'h0000_0000);
    cioc_field_model_i.pulse(0, 4);
    chk(REG_COUNT_BASE, 32'h0000_0001);
    $display("test up done");
  endtask

  // Counter request on pins still set as inputs reports the offending pin.
  task automatic t_conflict();
    cfg = '0;
    cfg.mode = MODE_CONTINUOUS_UP;
    cfg.a_ch = 3'h2;
    cfg.up_edge = COUNT_EDGE_RISING;
    wr(REG_CFG_BASE + 8'h04, 32'(cfg));
    chk(REG_STAT_BASE + 8'h04, 32'h0000_0004);
    wr(REG_CFG_BASE + 8'h04, 32'h0000_0007);
    chk(REG_STAT_BASE + 8'h04, 32'h0000_0100);
    $display("test conflict done");
  endtask

  // Sets all pins and waits until synchroniser and counters have followed.
  task automatic settle(input logic [31:0] v);
    cioc_field_model_i.set_all(v);
    repeat (8) @(posedge ref_clk_i);
  endtask

  // Quadrature on block 1: A on 8, B on 9, index on 10 active high, sync on 11.
  task automatic t_quad();
    logic [31:0] seq [4];
    seq = '{32'h0000_0100, 32'h0000_0300, 32'h0000_0200, 32'h0000_0000};
    wr(REG_FUNC_BASE + 8'h04, 32'h0000_003f);
    cfg = '0;
    cfg.mode = MODE_QUAD;
    cfg.b_ch = 3'h1;
    cfg.idx_ch = 3'h2;
    cfg.idx_en = 1'b1;
    cfg.idx_pol = 1'b1;
    cfg.sync_ch = 3'h3;
    cfg.sync_en = 1'b1;
    wr(REG_CFG_BASE + 8'h04, 32'(cfg));
    chk(REG_STAT_BASE + 8'h04, 32'h0000_0000);
    for (int n = 0; n < 8; n++) settle(seq[n % 4]);
    settle(32'h0000_0200);
    chk(REG_COUNT_BASE + 8'h04, 32'h0000_0007);
    settle(32'h0000_0600);
    chk(REG_COUNT_BASE + 8'h04, 32'h0000_0000);
    settle(32'h0000_0200);
    settle(32'h0000_0000);
    chk(REG_COUNT_BASE + 8'h04, 32'h0000_0001);
    settle(32'h0000_0800);
    chk(REG_COUNT_BASE + 8'h04, 32'h0000_0000);
    settle(32'h0000_0000);
    $display("test quad done");
  endtask

  // Up/down on block 2: channel 16 up on rising, channel 17 down on both edges.
  task automatic t_updown();
    wr(REG_FUNC_BASE + 8'h08, 32'h0000_000a);
    wr(REG_OPT_BASE + 8'h08, 32'h0000_0311);
    cfg = '0;
    cfg.mode = MODE_UP_DOWN;
    cfg.up_edge = COUNT_EDGE_RISING;
    wr(REG_CFG_BASE + 8'h08, 32'(cfg));
    cioc_field_model_i.pulse(16, 3);
    cioc_field_model_i.pulse(17, 1);
    chk(REG_COUNT_BASE + 8'h08, 32'h0000_0001);
    $display("test updown done");
  endtask

  // Stop-on-match on block 3 with a stop count of 2 and two pulses, four edges.
  task automatic t_match();
    wr(REG_FUNC_BASE + 8'h0c, 32'h0000_0002);
    wr(REG_OPT_BASE + 8'h0c, 32'h0000_0002);
    cfg = '0;
    cfg.mode = MODE_STOP_ON_MATCH;
    cfg.up_edge = COUNT_EDGE_ANY;
    wr(REG_CFG_BASE + 8'h0c, 32'(cfg));
    cioc_field_model_i.pulse(24, 2);
    chk(REG_COUNT_BASE + 8'h0c, 32'h0000_0002);
    $display("test match done");
  endtask

  // Watchdog well beyond the roughly 650 cycles the tests take.
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    num_errors++;
    end_of_test();
  end

  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    chk(REG_COUNT_BASE, 32'h0000_0000);
    t_levels();
    t_irq();
    t_up();
    t_conflict();
    t_quad();
    t_updown();
    t_match();
    end_of_test();
  end
endmodule
